//--- rtl/aog_corr_add.sv
// Correction adder: adds the scaled per-axis correction to both sample sets.
// Assumes the controlling end holds offsets and range steady per sample.
`timescale 1ns/1ps
module aog_corr_add (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Sample path
    aog_corr_if.adder cif
);
    import aog_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Scaled, saturating sum of one sample and one correction
    function automatic aog_sample_t corr_sum(input aog_sample_t smp,
                                             input logic [7:0]  off,
                                             input logic [1:0]  rng);
        logic signed [DATA_W+1:0] step;
        logic signed [DATA_W+1:0] wide;
        // R5 step scaled to range
        step = (DATA_W+2)'($signed(off)) <<< (SHIFT_AT_2G - rng);
        wide = (DATA_W+2)'($signed(smp)) + step;
        // R19 clamp not wrap
        if (wide > (DATA_W+2)'(SAMPLE_MAX)) begin
            corr_sum = DATA_W'(SAMPLE_MAX);
        end else if (wide < (DATA_W+2)'(SAMPLE_MIN)) begin
            corr_sum = DATA_W'(SAMPLE_MIN);
        end else begin
            corr_sum = DATA_W'(wide);
        end
    endfunction : corr_sum

    ////////////////////////////////////////////////////////////////////////
    // Corrected outputs, one cycle after the input set
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cif.out_valid <= 1'b0;
            cif.raw_out   <= '0;
            cif.filt_out  <= '0;
        end else begin
            cif.out_valid <= cif.in_valid;
            if (cif.in_valid) begin
                for (int a = 0; a < AXES; a++) begin
                    // R1 R2 R3 both sets corrected
                    cif.raw_out[a]  <= corr_sum(cif.raw_in[a], cif.offset[a], cif.range);
                    cif.filt_out[a] <= corr_sum(cif.filt_in[a], cif.offset[a], cif.range);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    property p_step_16g;
        (cif.in_valid && cif.range == 2'h3 && cif.filt_in[0] == '0)
        |=> (cif.filt_out[0] == DATA_W'($signed($past(cif.offset[0]))));
    endproperty
    a_step_16g : assert property (p_step_16g) else $error("16 g step wrong"); // R4

    property p_saturate;
        (cif.in_valid && cif.raw_in[0] == DATA_W'(SAMPLE_MAX) && !cif.offset[0][7])
        |=> (cif.raw_out[0] == DATA_W'(SAMPLE_MAX));
    endproperty
    a_saturate : assert property (p_saturate) else $error("sum wrapped"); // R19

endmodule : aog_corr_add

//--- rtl/aog_corr_if.sv
// Carrier between the register slice and the correction adder.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface aog_corr_if;
    import aog_pkg::*;
    logic [AXES-1:0][7:0] offset;    // Correction per axis
    logic [1:0]           range;     // Active g-range code
    logic                 in_valid;  // New sample set
    aog_axes_t            raw_in;    // Unfiltered samples
    aog_axes_t            filt_in;   // Filtered samples
    logic                 out_valid; // Corrected set ready
    aog_axes_t            raw_out;   // Corrected unfiltered
    aog_axes_t            filt_out;  // Corrected filtered
    modport ctrl  (output offset, range, in_valid, raw_in, filt_in,
                   input  out_valid, raw_out, filt_out);
    modport adder (input  offset, range, in_valid, raw_in, filt_in,
                   output out_valid, raw_out, filt_out);
endinterface : aog_corr_if

//--- rtl/aog_pkg.sv
// Constants and types for the axis correction, spare byte and buffer setup slice.
// Assumes an 8-bit register port and all sample logic on the system clock.
package aog_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_X_CORR    = 8'h38;
    localparam logic [7:0] ADDR_Y_CORR    = 8'h39;
    localparam logic [7:0] ADDR_Z_CORR    = 8'h3a;
    localparam logic [7:0] ADDR_SPARE0    = 8'h3b;
    localparam logic [7:0] ADDR_SPARE1    = 8'h3c;
    localparam logic [7:0] ADDR_BUF_SETUP = 8'h3e;
    // Reset values
    localparam logic [7:0] CORR_RESET  = 8'h00;
    localparam logic [7:0] SPARE_RESET = 8'h00;
    localparam logic [7:0] SETUP_RESET = 8'h00;
    // Buffer setup field positions
    localparam int MODE_LSB = 6;
    localparam int SEL_LSB  = 0;
    // Buffer modes
    localparam logic [1:0] MODE_BYPASS = 2'h0;
    localparam logic [1:0] MODE_FIFO   = 2'h1;
    localparam logic [1:0] MODE_STREAM = 2'h2;
    // Axis selections
    localparam logic [1:0] SEL_XYZ = 2'h0;
    localparam logic [1:0] SEL_X   = 2'h1;
    localparam logic [1:0] SEL_Y   = 2'h2;
    localparam logic [1:0] SEL_Z   = 2'h3;
    // Sizes
    localparam int DATA_W    = 12;
    localparam int AXES      = 3;
    localparam int BUF_DEPTH = 32;
    localparam int NVM_BYTES = 5;
    localparam int SPARES    = 2;
    // Image byte of the first spare byte, corrections sit below it
    localparam int NVM_IDX_SPARE = 3;
    // One step is 1/128 g; in the 2 g range that is 8 LSB, a shift of 3
    localparam logic [1:0] SHIFT_AT_2G = 2'h3;
    // Output word limits
    localparam int SAMPLE_MAX = 2 ** (DATA_W - 1) - 1;
    localparam int SAMPLE_MIN = -(2 ** (DATA_W - 1));
    // Sample types
    typedef logic signed [DATA_W-1:0] aog_sample_t;
    typedef aog_sample_t [AXES-1:0] aog_axes_t;
endpackage : aog_pkg

//--- rtl/aog_regs.sv
// Behaviour
// R1 - Add x correction to filtered and raw x
// R2 - Add y correction to filtered and raw y
// R3 - Add z correction to filtered and raw z
// R4 - Correction is signed, 127 near 1 g
// R5 - Correction step weight independent of range
// R6 - Reload corrections from image after resets
// R7 - Host writes or compensation run sets corrections
// R8 - Corrections offered to image programming
// R9 - Two spare bytes, reset zero, no effect
// R10 - Spare bytes programmable and reloaded
// R11 - Setup write empties buffer, clears full
// R12 - Bypass holds one frame, newest replaces
// R13 - Fifo mode stops at 32 frames
// R14 - Stream mode drops oldest when full
// R15 - Host never programs mode three
// R16 - Axis select picks stored axes
// R17 - Clear bit zeroes all three corrections
// R18 - Reload copies image; host waits ready
// R19 - Sum saturates instead of wrapping
// R20 - Reserved setup bits stored, not acted on
//
// Top of the register slice: corrections, spare bytes, buffer setup and buffer.
// Assumes the serial interface, image store and compensation engine share clk_i.
`timescale 1ns/1ps
module aog_regs #(
    parameter int DEPTH = aog_pkg::BUF_DEPTH  // Buffer frames
) (
    // Clock and reset
    input  wire logic                                clk_i,
    input  wire logic                                rstn_i,
    // Register port
    input  wire logic [7:0]                          reg_addr_i,
    input  wire logic [7:0]                          reg_wdata_i,
    input  wire logic                                reg_wr_i,
    input  wire logic                                reg_rd_i,
    output logic      [7:0]                          reg_rdata_o,
    // Image store
    input  wire logic [aog_pkg::NVM_BYTES-1:0][7:0]  nvm_image_i,
    input  wire logic                                soft_reset_i,
    input  wire logic                                nvm_load_i,
    output logic                                     nvm_rdy_o,
    output logic      [aog_pkg::NVM_BYTES-1:0][7:0]  nvm_image_o,
    // Compensation engine
    input  wire logic                                offset_clear_i,
    input  wire logic [1:0]                          foc_axis_i,
    input  wire logic [7:0]                          foc_value_i,
    // Samples
    input  wire logic [1:0]                          range_i,
    input  wire logic                                smp_valid_i,
    input  wire aog_pkg::aog_axes_t                  raw_i,
    input  wire aog_pkg::aog_axes_t                  filt_i,
    output logic                                     corr_valid_o,
    output aog_pkg::aog_axes_t                       raw_corr_o,
    output aog_pkg::aog_axes_t                       filt_corr_o,
    // Buffer read side
    input  wire logic                                buf_pop_i,
    output aog_pkg::aog_axes_t                       buf_data_o,
    output logic      [$clog2(DEPTH):0]              buf_level_o,
    output logic                                     buf_full_o
);
    import aog_pkg::*;

    localparam int PW = $clog2(DEPTH);  // Pointer width

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    typedef enum logic {LD_IDLE, LD_COPY} aog_load_e;

    aog_load_e              ld_state;    // Image loader state
    aog_load_e              next_ld;     // Loader next state
    logic [AXES-1:0][7:0]   corr;        // Axis corrections
    logic [SPARES-1:0][7:0] spare;       // Spare bytes
    logic [7:0]             setup;       // Buffer setup
    logic [1:0]             buf_mode;    // Mode field
    logic [1:0]             buf_sel;     // Axis select field
    logic                   setup_wr;    // Setup written this cycle
    logic                   copy_now;    // Image copied this cycle
    aog_axes_t              mem [DEPTH]; // Frame storage
    logic [PW-1:0]          wr_ptr;      // Write pointer
    logic [PW-1:0]          rd_ptr;      // Read pointer
    logic [PW:0]            count;       // Frames held
    logic [PW:0]            next_count;  // Count after this cycle
    logic                   push;        // Corrected frame arrives
    logic                   pop_ok;      // Pop of a held frame
    logic                   store_en;    // Frame is stored
    logic                   drop_old;    // Oldest frame discarded
    logic                   rd_adv;      // Read pointer moves
    aog_axes_t              entry;       // Frame as stored

    aog_corr_if cif ();  // Link to the adder

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    // Write strobe that hits one address
    function automatic logic wr_hit(input logic       wr,
                                    input logic [7:0] addr,
                                    input logic [7:0] at);
        wr_hit = wr && (addr == at);
    endfunction : wr_hit

    // Shape a frame for the selected axes; single axis sits in slot 0
    function automatic aog_axes_t shape(input aog_axes_t f, input logic [1:0] sel);
        shape = '0;
        case (sel)
            SEL_XYZ: shape    = f;
            SEL_X:   shape[0] = f[0];
            SEL_Y:   shape[0] = f[1];
            SEL_Z:   shape[0] = f[2];
            default: shape    = f;
        endcase
    endfunction : shape

    ////////////////////////////////////////////////////////////////////////
    // Image loader: a copy after reset release, soft reset or load trigger
    always_comb begin
        next_ld = ld_state;
        case (ld_state)
            // Idle until a reload cause
            LD_IDLE: begin
                if (soft_reset_i || nvm_load_i) begin
                    next_ld = LD_COPY;
                end
            end
            // One copy cycle, again if a new cause is pending
            LD_COPY: begin
                if (!(soft_reset_i || nvm_load_i)) begin
                    next_ld = LD_IDLE;
                end
            end
            default: next_ld = LD_IDLE;
        endcase
    end

    // R6 reload after reset
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ld_state  <= LD_COPY;
            nvm_rdy_o <= 1'b0;
        end else begin
            ld_state  <= next_ld;
            // R18 ready when idle
            nvm_rdy_o <= (next_ld == LD_IDLE);
        end
    end

    assign copy_now = (ld_state == LD_COPY);

    ////////////////////////////////////////////////////////////////////////
    // Corrections: copy beats clear, clear beats compensation, then host
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            corr <= {AXES{CORR_RESET}};
        end else begin
            for (int a = 0; a < AXES; a++) begin
                if (copy_now) begin
                    // R6 image restore
                    corr[a] <= nvm_image_i[a];
                end else if (offset_clear_i) begin
                    // R17 zero corrections
                    corr[a] <= CORR_RESET;
                end else if (foc_axis_i == 2'(a + 1)) begin
                    // R7 compensation result
                    corr[a] <= foc_value_i;
                end else if (wr_hit(reg_wr_i, reg_addr_i, ADDR_X_CORR + 8'(a))) begin
                    // R7 host write
                    corr[a] <= reg_wdata_i;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Spare bytes: storage only, read by the host and copied to the image output
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            spare <= {SPARES{SPARE_RESET}};
        end else begin
            for (int s = 0; s < SPARES; s++) begin
                if (copy_now) begin
                    // R10 image restore
                    spare[s] <= nvm_image_i[NVM_IDX_SPARE + s];
                end else if (wr_hit(reg_wr_i, reg_addr_i, ADDR_SPARE0 + 8'(s))) begin
                    // R9 plain storage
                    spare[s] <= reg_wdata_i;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Buffer setup; reserved bits are kept as written
    assign setup_wr = wr_hit(reg_wr_i, reg_addr_i, ADDR_BUF_SETUP);
    assign buf_mode = setup[MODE_LSB +: 2];
    assign buf_sel  = setup[SEL_LSB +: 2];

    // R20 store all bits
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            setup <= SETUP_RESET;
        end else if (setup_wr) begin
            setup <= reg_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the read strobe; unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_X_CORR:    reg_rdata_o <= corr[0];
                ADDR_Y_CORR:    reg_rdata_o <= corr[1];
                ADDR_Z_CORR:    reg_rdata_o <= corr[2];
                ADDR_SPARE0:    reg_rdata_o <= spare[0];
                ADDR_SPARE1:    reg_rdata_o <= spare[1];
                ADDR_BUF_SETUP: reg_rdata_o <= setup;
                default:        reg_rdata_o <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // R8 image offered for programming
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            nvm_image_o <= '0;
        end else begin
            nvm_image_o <= {spare, corr};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Correction adder
    assign cif.offset   = corr;
    assign cif.range    = range_i;
    assign cif.in_valid = smp_valid_i;
    assign cif.raw_in   = raw_i;
    assign cif.filt_in  = filt_i;

    aog_corr_add u_add (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .cif    (cif.adder)
    );

    assign corr_valid_o = cif.out_valid;
    assign raw_corr_o   = cif.raw_out;
    assign filt_corr_o  = cif.filt_out;

    ////////////////////////////////////////////////////////////////////////
    // Buffer policy per mode; mode three stores nothing
    assign push   = cif.out_valid;
    assign pop_ok = buf_pop_i && (count != '0);
    assign entry  = shape(cif.filt_out, buf_sel);

    always_comb begin
        store_en = 1'b0;
        drop_old = 1'b0;
        case (buf_mode)
            // R12 newest replaces
            MODE_BYPASS: begin
                store_en = push;
                drop_old = push && (count != '0) && !pop_ok;
            end
            // R13 stop when full
            MODE_FIFO: begin
                store_en = push && (count != (PW+1)'(DEPTH));
            end
            // R14 drop oldest
            MODE_STREAM: begin
                store_en = push;
                drop_old = push && (count == (PW+1)'(DEPTH)) && !pop_ok;
            end
            default: store_en = 1'b0;
        endcase
    end

    assign rd_adv     = pop_ok || drop_old;
    assign next_count = count + (PW+1)'(store_en) - (PW+1)'(rd_adv);

    // R11 setup write flushes
    always_ff @(posedge clk_i) begin
        if (!rstn_i || setup_wr) begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            count       <= '0;
            buf_level_o <= '0;
            buf_full_o  <= 1'b0;
        end else begin
            if (store_en) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (rd_adv) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count       <= next_count;
            buf_level_o <= next_count;
            buf_full_o  <= (next_count == (PW+1)'(DEPTH));
        end
    end

    // R16 selected axes stored
    always_ff @(posedge clk_i) begin
        if (store_en) begin
            mem[wr_ptr] <= entry;
        end
    end

    // Oldest frame, shown one cycle after the pointer settles
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            buf_data_o <= '0;
        end else begin
            buf_data_o <= mem[rd_ptr];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    property p_reload;
        copy_now |=> (corr == $past(nvm_image_i[2:0]))
                     && (spare == $past(nvm_image_i[4:3]));
    endproperty
    a_reload : assert property (p_reload) else $error("image not restored"); // R6

    property p_soft_reset;
        soft_reset_i |=> copy_now ##1 (nvm_rdy_o || copy_now);
    endproperty
    a_soft_reset : assert property (p_soft_reset) else $error("no reload"); // R18

    property p_clear;
        (offset_clear_i && !copy_now) |=> (corr == '0);
    endproperty
    a_clear : assert property (p_clear) else $error("clear ignored"); // R17

    property p_foc_y;
        (foc_axis_i == 2'h2 && !copy_now && !offset_clear_i)
        |=> (corr[1] == $past(foc_value_i)) && $stable(corr[0]);
    endproperty
    a_foc_y : assert property (p_foc_y) else $error("compensation lost"); // R7

    property p_spare_wr;
        (wr_hit(reg_wr_i, reg_addr_i, ADDR_SPARE1) && !copy_now)
        |=> (spare[1] == $past(reg_wdata_i)) ##1 (nvm_image_o[4] == $past(spare[1]));
    endproperty
    a_spare_wr : assert property (p_spare_wr) else $error("spare write lost"); // R9

    property p_flush;
        setup_wr |=> (buf_level_o == '0) && !buf_full_o && (count == '0);
    endproperty
    a_flush : assert property (p_flush) else $error("buffer not flushed"); // R11

    property p_bypass;
        (buf_mode == MODE_BYPASS) |-> (count <= (PW+1)'(1));
    endproperty
    a_bypass : assert property (p_bypass) else $error("bypass over one"); // R12

    property p_fifo_stop;
        (buf_mode == MODE_FIFO && count == (PW+1)'(DEPTH) && push && !buf_pop_i
         && !setup_wr) |=> $stable(wr_ptr) && (count == (PW+1)'(DEPTH));
    endproperty
    a_fifo_stop : assert property (p_fifo_stop) else $error("stored past full"); // R13

    property p_stream_drop;
        (buf_mode == MODE_STREAM && count == (PW+1)'(DEPTH) && push && !buf_pop_i
         && !setup_wr) |=> (rd_ptr == $past(rd_ptr) + 1'b1) && buf_full_o;
    endproperty
    a_stream_drop : assert property (p_stream_drop) else $error("oldest kept"); // R14

    property p_sel_x;
        (store_en && buf_sel == SEL_X) |=> (mem[$past(wr_ptr)][0] == $past(cif.filt_out[0]))
                                          && (mem[$past(wr_ptr)][2] == '0);
    endproperty
    a_sel_x : assert property (p_sel_x) else $error("wrong axis stored"); // R16

    c_stream_full : cover property (buf_mode == MODE_STREAM && drop_old);
    c_fifo_full   : cover property (buf_mode == MODE_FIFO && buf_full_o && push);
    c_reload      : cover property (nvm_load_i && nvm_rdy_o ##1 copy_now);
    c_bypass_new  : cover property (buf_mode == MODE_BYPASS && drop_old);

endmodule : aog_regs

//--- tb/aog_host_model.sv
// Host side of the register port: single-byte reads and writes.
// Assumes the slice samples the strobes on the rising clock edge.
`timescale 1ns/1ps
module aog_host_model (
    // Clock
    input  wire logic       clk_i,
    // Register strobes
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o
);
    // Idle port at time zero
    initial begin
        {addr_o, wdata_o, wr_o, rd_o} = 18'h0;
    end
    // One access: strobe held for one edge, then strobes drop and address and data are inverted
    // data byte driven as given; mode codes and reserved bits are not checked
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        {addr_o, wdata_o, wr_o, rd_o} = {a, d, w, !w};
        @(negedge clk_i);
        {addr_o, wdata_o, wr_o, rd_o} = {~a, ~d, 2'b00};
    endtask : acc
endmodule : aog_host_model

//--- tb/tb_top.sv
// Bench for the correction, spare byte and buffer setup slice.
// Assumes one clock; two queues of notes are checked by the monitor.
`timescale 1ns/1ps
module tb_top;
    import aog_pkg::*;
    localparam int DEPTH = 4;
    logic clk_i = 0, rstn_i = 0, soft_reset_i = 0, nvm_load_i = 0, offset_clear_i = 0;
    logic smp_valid_i = 0, buf_pop_i = 0, nvm_rdy_o, corr_valid_o, buf_full_o, rd_d = 0;
    logic [1:0] foc_axis_i = 0, range_i = 0;
    logic [7:0] foc_value_i = 0, reg_addr_i, reg_wdata_i, reg_rdata_o, cx, v;
    logic reg_wr_i, reg_rd_i;
    logic [NVM_BYTES-1:0][7:0] nvm_image_i = '0, nvm_image_o;
    aog_axes_t raw_i = '0, filt_i = '0, raw_corr_o, filt_corr_o, buf_data_o;
    logic [$clog2(DEPTH):0] buf_level_o;
    logic [11:0] qr[$], qs[$];
    int n_fail = 0, cmp_count = 0, cyc = 0;
    ////////////////////////////////////////////////////////////////////
    initial forever #2 clk_i = ~clk_i;
    aog_host_model host (.clk_i(clk_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i),
        .wr_o(reg_wr_i), .rd_o(reg_rd_i));
    aog_regs #(.DEPTH(DEPTH)) dut (.clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .nvm_image_i(nvm_image_i), .soft_reset_i(soft_reset_i),
        .nvm_load_i(nvm_load_i), .nvm_rdy_o(nvm_rdy_o), .nvm_image_o(nvm_image_o),
        .offset_clear_i(offset_clear_i), .foc_axis_i(foc_axis_i), .foc_value_i(foc_value_i),
        .range_i(range_i), .smp_valid_i(smp_valid_i), .raw_i(raw_i), .filt_i(filt_i),
        .corr_valid_o(corr_valid_o), .raw_corr_o(raw_corr_o), .filt_corr_o(filt_corr_o),
        .buf_pop_i(buf_pop_i), .buf_data_o(buf_data_o), .buf_level_o(buf_level_o),
        .buf_full_o(buf_full_o));
    ////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    // Verdict and end of run
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    // Read with a note of the expected byte
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        qr.push_back({4'h0, e});
        host.acc(1'b0, a, 8'h00);
    endtask : rd
    // One x sample; expected sum is scaled and clamped
    task automatic smp(input logic [1:0] r, input logic [11:0] x);
        int s;
        s = $signed(x) + $signed(cx) * (2 ** (3 - r));
        s = s > SAMPLE_MAX ? SAMPLE_MAX : (s < SAMPLE_MIN ? SAMPLE_MIN : s);
        qs.push_back(12'(s));
        @(negedge clk_i);
        range_i = r;
        raw_i[0] = x;
        filt_i[0] = x;
        smp_valid_i = 1;
        @(negedge clk_i);
        smp_valid_i = 0;
    endtask : smp
    // Buffer level and full flag once settled
    task automatic lvl(input int n, input logic f);
        repeat (2) @(negedge clk_i);
        chk(12'(buf_level_o), 12'(n));
        chk(12'(buf_full_o), 12'(f));
    endtask : lvl
    ////////////////////////////////////////////////////////////////////
    // Monitor: read data and corrected samples against the notes
    always @(posedge clk_i) begin
        if (rd_d) chk({4'h0, reg_rdata_o}, qr.pop_front());
        rd_d <= reg_rd_i;
        if (corr_valid_o === 1'b1) begin
            chk(raw_corr_o[0], qs[0]);
            chk(filt_corr_o[0], qs.pop_front());
        end
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h5ab1f706));
        foreach (nvm_image_i[i]) nvm_image_i[i] = 8'($urandom);
        repeat (20) @(negedge clk_i);
        rstn_i = 1;
        repeat (3) @(negedge clk_i);
        chk(12'(nvm_rdy_o), 12'h001);
        for (int i = 0; i < 5; i++) rd(ADDR_X_CORR + 8'(i), nvm_image_i[i]);
        rd(ADDR_BUF_SETUP, SETUP_RESET);
        rd(8'h3d, 8'h00);
        v = 8'($urandom);
        host.acc(1'b1, ADDR_SPARE1, v);
        rd(ADDR_SPARE1, v);
        chk(12'(nvm_image_o[4]), 12'(v));
        @(negedge clk_i);
        {foc_axis_i, foc_value_i} = {2'h2, 8'h9c};
        @(negedge clk_i);
        foc_axis_i = 2'h0;
        rd(ADDR_Y_CORR, 8'h9c);
        @(negedge clk_i);
        offset_clear_i = 1;
        @(negedge clk_i);
        offset_clear_i = 0;
        rd(ADDR_Y_CORR, 8'h00);
        for (int k = 0; k < 8; k++) begin
            cx = k < 4 ? 8'h80 : 8'h7f;
            host.acc(1'b1, ADDR_X_CORR, cx);
            smp(2'(k), k == 7 ? 12'h7ff : (k == 3 ? 12'h000 : 12'($urandom)));
        end
        for (int k = 0; k < 2; k++) begin
            foreach (nvm_image_i[i]) nvm_image_i[i] = 8'($urandom);
            @(negedge clk_i);
            {nvm_load_i, soft_reset_i} = {k == 0, k == 1};
            @(negedge clk_i);
            {nvm_load_i, soft_reset_i} = 2'b00;
            chk(12'(nvm_rdy_o), 12'h000);
            @(negedge clk_i);
            for (int i = 0; i < 5; i++) rd(ADDR_X_CORR + 8'(i), nvm_image_i[i]);
        end
        cx = nvm_image_i[0];
        host.acc(1'b1, ADDR_BUF_SETUP, {MODE_FIFO, 6'h00});
        repeat (DEPTH + 2) smp(2'h1, 12'h010);
        lvl(DEPTH, 1);
        host.acc(1'b1, ADDR_BUF_SETUP, {MODE_STREAM, 6'h00});
        lvl(0, 0);
        repeat (DEPTH + 1) smp(2'h2, 12'hf00);
        lvl(DEPTH, 1);
        host.acc(1'b1, ADDR_BUF_SETUP, {MODE_BYPASS, 4'h0, SEL_X});
        repeat (2) smp(2'h3, 12'h123);
        lvl(1, 0);
        chk(buf_data_o[0], 12'h123 + 12'($signed(cx)));
        chk(buf_data_o[2], 12'h000);
        rd(ADDR_BUF_SETUP, {MODE_BYPASS, 4'h0, SEL_X});
        repeat (4) @(negedge clk_i);
        finish_test();
    end
endmodule : tb_top
